//--- core/svlm_pkg.sv
// Operation
// - Sensing off on both pins forces conditions low
// - Forced drop on disable counts as change
// - Low and high sources merge into one irq
// - Interrupt delivered only in CPU run mode
// - Stop mode entry or exit keeps flags
// - Low-voltage events only while a pin senses
// - Two-bit field picks one of four low levels
// - One bit picks one of two high levels
// - Low condition change sets low flag
// - Low flag cleared only by writing one
// - High condition change sets high flag
// - High flag cleared only by writing one
// - Low request needs flag and its enable
// - High request needs flag and its enable
// - Sense-pin enable clears supply-pin enable
package svlm_pkg;

  // Bus geometry
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] ADDR_ENABLE = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h04;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = 5'h08;
  localparam logic [ADDR_W-1:0] ADDR_FLAG = 5'h0c;

  // Enable register fields
  localparam int EN_SENSE_LEVEL = 0;
  localparam int EN_SENSE_ADC = 1;
  localparam int EN_SUPPLY_LEVEL = 2;
  localparam int EN_SUPPLY_ADC = 3;
  localparam int EN_LOW_SEL_LSB = 4;
  localparam int EN_LOW_SEL_MSB = 5;
  localparam int EN_HIGH_SEL = 6;
  localparam int EN_SPARE = 7;

  // Status, flag and irq enable share this layout
  localparam int BIT_LOW = 0;
  localparam int BIT_HIGH = 1;

  // Values after reset
  localparam logic RESET_BIT = 1'h0;
  localparam logic [1:0] RESET_LOW_SEL = 2'h0;
  localparam logic [DATA_W-1:0] RESET_WORD = 32'h0000_0000;

  // Threshold select encodings
  localparam logic [1:0] LOW_LEVEL_1 = 2'h0;
  localparam logic [1:0] LOW_LEVEL_2 = 2'h1;
  localparam logic [1:0] LOW_LEVEL_3 = 2'h2;
  localparam logic [1:0] LOW_LEVEL_4 = 2'h3;
  localparam logic HIGH_LEVEL_1 = 1'h0;
  localparam logic HIGH_LEVEL_2 = 1'h1;

  // Bus handshake, Gray coded
  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0,
    BUS_ACK = 2'h1
  } svlm_bus_state_t;

endpackage : svlm_pkg

//--- core/svlm_sync_if.sv
// Raw comparator levels in, clean levels out
interface svlm_sync_if;
  logic [1:0] raw;
  logic [1:0] clean;

  modport sync_side (
    input raw,
    output clean
  );

  modport core_side (
    output raw,
    input clean
  );
endinterface : svlm_sync_if

//--- core/svlm_sync.sv
// Three-stage input synchroniser with agreement filter
module svlm_sync (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Comparator levels
  svlm_sync_if.sync_side sync
);

  genvar i;

  // One chain per comparator bit
  generate
    for (i = 0; i < 2; i++) begin : g_bit
      logic stage1;
      logic stage2;
      logic stage3;
      logic level;
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          stage1 <= svlm_pkg::RESET_BIT;
          stage2 <= svlm_pkg::RESET_BIT;
          stage3 <= svlm_pkg::RESET_BIT;
          level <= svlm_pkg::RESET_BIT;
        end else begin
          stage1 <= sync.raw[i];
          stage2 <= stage1;
          stage3 <= stage2;
          // Only agreed levels pass, so one bad sample is dropped
          if (stage2 == stage3) begin
            level <= stage3;
          end
        end
      end
      assign sync.clean[i] = level;
    end
  endgenerate

endmodule : svlm_sync

//--- core/svlm_top.sv
// Supply voltage level monitor: control, status and interrupt logic
module svlm_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [svlm_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [svlm_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [svlm_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Analog comparator results, asynchronous
  input wire logic raw_low_compare,
  input wire logic raw_high_compare,
  // CPU mode, same clock domain
  input wire logic cpu_run_mode,
  // Analog front-end controls
  output logic sense_pin_level_enable,
  output logic supply_pin_level_enable,
  output logic sense_pin_adc_connect,
  output logic supply_pin_adc_connect,
  output logic [1:0] low_threshold_select,
  output logic high_threshold_select,
  output logic [3:0] low_level_onehot,
  output logic [1:0] high_level_onehot,
  // Condition outputs
  output logic low_condition,
  output logic high_condition,
  // Interrupt request
  output logic monitor_irq
);

  // Internal state
  svlm_pkg::svlm_bus_state_t bus_state;
  svlm_pkg::svlm_bus_state_t next_bus_state;
  logic low_change_flag;
  logic high_change_flag;
  logic low_irq_enable;
  logic high_irq_enable;

  // Next values
  logic next_waitrequest;
  logic [svlm_pkg::DATA_W-1:0] next_readdata;
  logic next_low_condition;
  logic next_high_condition;
  logic next_low_change_flag;
  logic next_high_change_flag;
  logic next_monitor_irq;
  logic next_supply_level;
  logic next_supply_adc;
  logic [3:0] next_low_onehot;
  logic [1:0] next_high_onehot;

  // Decode and helper wires
  logic request;
  logic capture;
  logic access_done;
  logic write_done;
  logic lane0;
  logic sel_enable;
  logic sel_status;
  logic sel_irq_enable;
  logic sel_flag;
  logic mapped;
  logic wr_enable;
  logic wr_irq_enable;
  logic wr_flag;
  logic sense_active;
  logic low_changed;
  logic high_changed;
  logic low_clear;
  logic high_clear;
  logic low_irq_source;
  logic high_irq_source;
  logic [svlm_pkg::REG_W-1:0] enable_word;
  logic [svlm_pkg::REG_W-1:0] status_word;
  logic [svlm_pkg::REG_W-1:0] irq_enable_word;
  logic [svlm_pkg::REG_W-1:0] flag_word;
  logic [svlm_pkg::REG_W-1:0] read_byte;
  logic [svlm_pkg::REG_W-1:0] wbyte;

  // Synchroniser link
  svlm_sync_if sync_link ();

  assign sync_link.raw[svlm_pkg::BIT_LOW] = raw_low_compare;
  assign sync_link.raw[svlm_pkg::BIT_HIGH] = raw_high_compare;

  // comparator synchroniser
  // Comparators are analog and free running, never trust a raw level
  svlm_sync u_sync (
    .ref_clk (ref_clk),
    .rst (rst),
    .sync (sync_link.sync_side)
  );

  // Bus handshake: request seen, one cycle later waitrequest drops
  // Fixed single wait cycle keeps the decode off the critical path

  // Request qualification
  assign request = avs_read | avs_write;
  assign capture = (bus_state == svlm_pkg::BUS_IDLE) & request;
  assign access_done = (bus_state == svlm_pkg::BUS_ACK) & request;
  assign lane0 = avs_byteenable[0];
  assign write_done = access_done & avs_write & lane0;
  assign wbyte = avs_writedata[svlm_pkg::REG_W-1:0];

  // Handshake sequencing
  always_comb begin
    next_bus_state = svlm_pkg::BUS_IDLE;
    case (bus_state)
      svlm_pkg::BUS_IDLE: begin
        if (request) begin
          next_bus_state = svlm_pkg::BUS_ACK;
        end
      end
      svlm_pkg::BUS_ACK: begin
        next_bus_state = svlm_pkg::BUS_IDLE;
      end
      default: begin
        next_bus_state = svlm_pkg::BUS_IDLE;
      end
    endcase
  end

  // Waitrequest low only in the acknowledge cycle
  // Idle level is high, so every request waits one cycle
  assign next_waitrequest = (next_bus_state != svlm_pkg::BUS_ACK);

  // Handshake registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bus_state <= svlm_pkg::BUS_IDLE;
      avs_waitrequest <= 1'h1;
    end else begin
      bus_state <= next_bus_state;
      avs_waitrequest <= next_waitrequest;
    end
  end

  // Address decode
  // Full compare, so aliases of a register read as unmapped

  // Register selects; everything else is unmapped
  assign sel_enable = (avs_address == svlm_pkg::ADDR_ENABLE);
  assign sel_status = (avs_address == svlm_pkg::ADDR_STATUS);
  assign sel_irq_enable = (avs_address == svlm_pkg::ADDR_IRQ_ENABLE);
  assign sel_flag = (avs_address == svlm_pkg::ADDR_FLAG);
  assign mapped = sel_enable | sel_status | sel_irq_enable | sel_flag;

  // Write strobes; status is read only
  assign wr_enable = write_done & sel_enable;
  assign wr_irq_enable = write_done & sel_irq_enable;
  assign wr_flag = write_done & sel_flag;

  // Read words
  // Unused bits read back zero

  // Enable register image
  assign enable_word[svlm_pkg::EN_SENSE_LEVEL] = sense_pin_level_enable;
  assign enable_word[svlm_pkg::EN_SENSE_ADC] = sense_pin_adc_connect;
  assign enable_word[svlm_pkg::EN_SUPPLY_LEVEL] = supply_pin_level_enable;
  assign enable_word[svlm_pkg::EN_SUPPLY_ADC] = supply_pin_adc_connect;
  assign enable_word[svlm_pkg::EN_LOW_SEL_MSB:svlm_pkg::EN_LOW_SEL_LSB] = low_threshold_select;
  assign enable_word[svlm_pkg::EN_HIGH_SEL] = high_threshold_select;
  assign enable_word[svlm_pkg::EN_SPARE] = 1'h0;

  // Status, irq enable and flag images
  assign status_word = {6'h00, high_condition, low_condition};
  assign irq_enable_word = {6'h00, high_irq_enable, low_irq_enable};
  assign flag_word = {6'h00, high_change_flag, low_change_flag};

  // Read selection; unmapped reads return zero
  assign read_byte = sel_enable ? enable_word :
                     sel_status ? status_word :
                     sel_irq_enable ? irq_enable_word :
                     sel_flag ? flag_word : 8'h00;
  assign next_readdata = (avs_read & mapped) ? {24'h00_0000, read_byte} : svlm_pkg::RESET_WORD;

  // Read data held until the next request is captured
  // Captured with the request: a flag set during the wait shows next read
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      avs_readdata <= svlm_pkg::RESET_WORD;
    end else if (capture) begin
      avs_readdata <= next_readdata;
    end
  end

  // Enable register
  // One pin at a time, the divider cannot serve both

  // sense-pin enable wins over supply pin
  assign next_supply_level = wbyte[svlm_pkg::EN_SUPPLY_LEVEL] & ~wbyte[svlm_pkg::EN_SENSE_LEVEL];
  // Same exclusivity for the ADC path
  assign next_supply_adc = wbyte[svlm_pkg::EN_SUPPLY_ADC] & ~wbyte[svlm_pkg::EN_SENSE_ADC];

  // Pin enable registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sense_pin_level_enable <= svlm_pkg::RESET_BIT;
      supply_pin_level_enable <= svlm_pkg::RESET_BIT;
      sense_pin_adc_connect <= svlm_pkg::RESET_BIT;
      supply_pin_adc_connect <= svlm_pkg::RESET_BIT;
    end else if (wr_enable) begin
      sense_pin_level_enable <= wbyte[svlm_pkg::EN_SENSE_LEVEL];
      supply_pin_level_enable <= next_supply_level;
      sense_pin_adc_connect <= wbyte[svlm_pkg::EN_SENSE_ADC];
      supply_pin_adc_connect <= next_supply_adc;
    end
  end

  // Threshold select registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      low_threshold_select <= svlm_pkg::RESET_LOW_SEL;
      high_threshold_select <= svlm_pkg::RESET_BIT;
    end else if (wr_enable) begin
      low_threshold_select <= wbyte[svlm_pkg::EN_LOW_SEL_MSB:svlm_pkg::EN_LOW_SEL_LSB];
      high_threshold_select <= wbyte[svlm_pkg::EN_HIGH_SEL];
    end
  end

  // Threshold level decode for the comparator ladder
  // One-hot so the ladder switches never short two taps

  always_comb begin
    next_low_onehot = 4'h0;
    case (low_threshold_select)
      svlm_pkg::LOW_LEVEL_1: next_low_onehot = 4'h1;
      svlm_pkg::LOW_LEVEL_2: next_low_onehot = 4'h2;
      svlm_pkg::LOW_LEVEL_3: next_low_onehot = 4'h4;
      svlm_pkg::LOW_LEVEL_4: next_low_onehot = 4'h8;
      default: next_low_onehot = 4'h1;
    endcase
  end

  always_comb begin
    next_high_onehot = 2'h0;
    case (high_threshold_select)
      svlm_pkg::HIGH_LEVEL_1: next_high_onehot = 2'h1;
      svlm_pkg::HIGH_LEVEL_2: next_high_onehot = 2'h2;
      default: next_high_onehot = 2'h1;
    endcase
  end

  // Level selects lag the register by one cycle
  // Reset picks the lowest taps
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      low_level_onehot <= 4'h1;
      high_level_onehot <= 2'h1;
    end else begin
      low_level_onehot <= next_low_onehot;
      high_level_onehot <= next_high_onehot;
    end
  end

  // Conditions
  // Forced low here, not in the comparators, so a disable is seen

  // events only while a pin senses
  assign sense_active = sense_pin_level_enable | supply_pin_level_enable;
  // conditions forced low when sensing off
  assign next_low_condition = sense_active & sync_link.clean[svlm_pkg::BIT_LOW];
  assign next_high_condition = sense_active & sync_link.clean[svlm_pkg::BIT_HIGH];

  // Condition registers
  // Status, flag edge and read image all use this one copy
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      low_condition <= svlm_pkg::RESET_BIT;
      high_condition <= svlm_pkg::RESET_BIT;
    end else begin
      low_condition <= next_low_condition;
      high_condition <= next_high_condition;
    end
  end

  // Change flags
  // Set wins over a clear in the same cycle, so no edge is lost

  // forced drop seen as a change
  assign low_changed = next_low_condition ^ low_condition;
  assign high_changed = next_high_condition ^ high_condition;

  assign low_clear = wr_flag & wbyte[svlm_pkg::BIT_LOW];
  assign high_clear = wr_flag & wbyte[svlm_pkg::BIT_HIGH];

  assign next_low_change_flag = low_changed | (low_change_flag & ~low_clear);
  assign next_high_change_flag = high_changed | (high_change_flag & ~high_clear);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      low_change_flag <= svlm_pkg::RESET_BIT;
      high_change_flag <= svlm_pkg::RESET_BIT;
    end else begin
      low_change_flag <= next_low_change_flag;
      high_change_flag <= next_high_change_flag;
    end
  end

  // Interrupt
  // Level output; it stays up until software clears, masks or leaves run mode

  // Interrupt enable register, the mask for the flags
  // Masking leaves the flags recording changes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      low_irq_enable <= svlm_pkg::RESET_BIT;
      high_irq_enable <= svlm_pkg::RESET_BIT;
    end else if (wr_irq_enable) begin
      low_irq_enable <= wbyte[svlm_pkg::BIT_LOW];
      high_irq_enable <= wbyte[svlm_pkg::BIT_HIGH];
    end
  end

  assign low_irq_source = low_change_flag & low_irq_enable;
  assign high_irq_source = high_change_flag & high_irq_enable;
  assign next_monitor_irq = cpu_run_mode & (low_irq_source | high_irq_source);

  // Registered so the line never glitches
  // Run mode gates the request, the flags stay as they are
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      monitor_irq <= svlm_pkg::RESET_BIT;
    end else begin
      monitor_irq <= next_monitor_irq;
    end
  end

endmodule : svlm_top

//--- testbench/svlm_cmp_model.sv
// Analog comparators on the two sensed supply pins
module svlm_cmp_model #(
  parameter logic [7:0] LOW_BASE = 8'h20,
  parameter logic [7:0] HIGH_BASE = 8'h80,
  parameter logic [7:0] LVL_STEP = 8'h10
) (
  // Pin voltages, arbitrary units
  input wire logic [7:0] sense_v,
  input wire logic [7:0] supply_v,
  // Selection from the monitor
  input wire logic sense_pin_level_enable,
  input wire logic [1:0] low_threshold_select,
  input wire logic high_threshold_select,
  // Raw results, asynchronous
  output logic raw_low_compare,
  output logic raw_high_compare
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] pin_v;
  logic [7:0] low_trip;
  logic [7:0] high_trip;
  assign pin_v = sense_pin_level_enable ? sense_v : supply_v;
  assign low_trip = LOW_BASE + LVL_STEP * {6'h0, low_threshold_select};
  assign high_trip = HIGH_BASE + LVL_STEP * {7'h0, high_threshold_select};
  // Keeps comparing when sensing is off, so forcing is up to the monitor
  assign #1.3 raw_low_compare = pin_v < low_trip;
  assign #1.3 raw_high_compare = pin_v >= high_trip;
endmodule : svlm_cmp_model

//--- testbench/svlm_top_asserts.sv
// Port-level checks of the monitor
module svlm_top_asserts (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Bus write side
  input wire logic [svlm_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_write,
  input wire logic [svlm_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  // Comparator and mode
  input wire logic raw_low_compare,
  input wire logic cpu_run_mode,
  // Front-end controls
  input wire logic sense_pin_level_enable,
  input wire logic supply_pin_level_enable,
  input wire logic [1:0] low_threshold_select,
  input wire logic high_threshold_select,
  input wire logic [3:0] low_level_onehot,
  input wire logic [1:0] high_level_onehot,
  // Results
  input wire logic low_condition,
  input wire logic high_condition,
  input wire logic monitor_irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [1:0] ie_sh;
  logic ie_wr;
  logic level_on;
  // Irq enable shadow, taken at the accepting edge only
  assign ie_wr = avs_write && !avs_waitrequest && avs_byteenable[0]
    && (avs_address == svlm_pkg::ADDR_IRQ_ENABLE);
  assign level_on = sense_pin_level_enable || supply_pin_level_enable;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ie_sh <= 2'h0;
    end else if (ie_wr) begin
      ie_sh <= avs_writedata[1:0];
    end
  end
  // A condition edge with its source enabled
  sequence s_low_event;
    $changed(low_condition) && ie_sh[0] && cpu_run_mode;
  endsequence
  sequence s_high_event;
    $changed(high_condition) && ie_sh[1] && cpu_run_mode;
  endsequence
  a_forced_low: assert property ((!level_on)[*2] |-> !low_condition && !high_condition)
    else $error("condition high with sensing off");
  a_level_excl: assert property (sense_pin_level_enable |-> !supply_pin_level_enable)
    else $error("both pins sensed");
  a_low_onehot: assert property (low_level_onehot == (4'h1 << $past(low_threshold_select)))
    else $error("low level decode wrong");
  a_high_onehot: assert property (high_level_onehot == (2'h1 << $past(high_threshold_select)))
    else $error("high level decode wrong");
  a_low_irq_set: assert property (s_low_event |=> monitor_irq)
    else $error("low change gave no irq");
  a_high_irq_set: assert property (s_high_event |=> monitor_irq)
    else $error("high change gave no irq");
  a_irq_cause: assert property (monitor_irq |-> $past(cpu_run_mode) && $past(ie_sh) != 2'h0)
    else $error("irq without run mode or enable");
  a_sync_lag: assert property ($rose(raw_low_compare) && !low_condition |=> !low_condition)
    else $error("raw compare used unsynchronised");
endmodule : svlm_top_asserts

bind svlm_top svlm_top_asserts i_asserts (.ref_clk, .rst, .avs_address, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_waitrequest, .raw_low_compare, .cpu_run_mode,
  .sense_pin_level_enable, .supply_pin_level_enable, .low_threshold_select,
  .high_threshold_select, .low_level_onehot, .high_level_onehot, .low_condition,
  .high_condition, .monitor_irq);

//--- testbench/tb_svlm_top.sv
// Self-checking bench for the monitor
module tb_svlm_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] A_EN = svlm_pkg::ADDR_ENABLE;
  localparam logic [4:0] A_IE = svlm_pkg::ADDR_IRQ_ENABLE;
  localparam logic [4:0] A_FL = svlm_pkg::ADDR_FLAG;
  localparam logic [7:0] LOW_BASE = 8'h20;
  localparam logic [7:0] HIGH_BASE = 8'h80;
  localparam logic [7:0] LVL_STEP = 8'h10;
  localparam logic [7:0] MID_V = 8'h68;
  logic ref_clk, rst, avs_read, avs_write, avs_waitrequest, cpu_run_mode, monitor_irq;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd_data;
  logic [3:0] avs_byteenable, low_level_onehot;
  logic raw_low_compare, raw_high_compare, sense_pin_level_enable, supply_pin_level_enable;
  logic sense_pin_adc_connect, supply_pin_adc_connect, high_threshold_select;
  logic low_condition, high_condition;
  logic [1:0] low_threshold_select, high_level_onehot;
  logic [7:0] sense_v, supply_v;
  int bad_count, samples_checked;

  svlm_top i_dut (.ref_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .raw_low_compare, .raw_high_compare,
    .cpu_run_mode, .sense_pin_level_enable, .supply_pin_level_enable, .sense_pin_adc_connect,
    .supply_pin_adc_connect, .low_threshold_select, .high_threshold_select, .low_level_onehot,
    .high_level_onehot, .low_condition, .high_condition, .monitor_irq);
  svlm_cmp_model #(.LOW_BASE(LOW_BASE), .HIGH_BASE(HIGH_BASE), .LVL_STEP(LVL_STEP)) i_cmp (
    .sense_v, .supply_v, .sense_pin_level_enable, .low_threshold_select,
    .high_threshold_select, .raw_low_compare, .raw_high_compare);

  // Free-running bus clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d,
      input logic [3:0] be);
    int n;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    if (n >= 40) bad_count++;
    rd_data = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask : wr

  task automatic rd_chk(input string name, input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h0, 4'h1);
    chk(name, {24'h0, e}, rd_data);
  endtask : rd_chk

  // Bounded wait for the synchronised conditions
  task automatic wait_cond(input logic el, input logic eh);
    int n;
    n = 0;
    while ((low_condition !== el || high_condition !== eh) && n < 30) begin
      @(posedge ref_clk);
      n++;
    end
    chk("low_condition", {31'h0, el}, {31'h0, low_condition});
    chk("high_condition", {31'h0, eh}, {31'h0, high_condition});
  endtask : wait_cond

  // Irq is registered one edge behind its cause
  task automatic irq_is(input logic e);
    repeat (2) @(posedge ref_clk);
    chk("monitor_irq", {31'h0, e}, {31'h0, monitor_irq});
  endtask : irq_is

  task automatic t_regs;
    chk("low_level_onehot", 32'h1, {28'h0, low_level_onehot});
    for (int a = 0; a < 5; a++) rd_chk("reset value", 5'(a * 4), 8'h00);
    wr(A_EN, 8'h0c);
    rd_chk("enable", A_EN, 8'h0c);
    chk("adc connects", 32'h2, {30'h0, supply_pin_adc_connect, sense_pin_adc_connect});
    chk("level enables", 32'h2, {30'h0, supply_pin_level_enable, sense_pin_level_enable});
    wr(A_EN, 8'h03);
    rd_chk("enable", A_EN, 8'h03);
    chk("adc connects", 32'h1, {30'h0, supply_pin_adc_connect, sense_pin_adc_connect});
    chk("level enables", 32'h1, {30'h0, supply_pin_level_enable, sense_pin_level_enable});
    bus(1'b1, A_EN, 8'h40, 4'h0);
    rd_chk("enable lane off", A_EN, 8'h03);
    wr(svlm_pkg::ADDR_STATUS, 8'h03);
    rd_chk("status", svlm_pkg::ADDR_STATUS, 8'h00);
  endtask : t_regs

  task automatic t_levels;
    logic [7:0] lo, hi;
    for (int s = 0; s < 4; s++) begin
      lo = LOW_BASE + LVL_STEP * 8'(s);
      hi = HIGH_BASE + LVL_STEP * 8'(s % 2);
      wr(A_EN, {1'b0, 1'(s % 2), 2'(s), 4'h1});
      sense_v <= lo - 8'h1;
      wait_cond(1'b1, 1'b0);
      sense_v <= lo;
      wait_cond(1'b0, 1'b0);
      sense_v <= hi;
      wait_cond(1'b0, 1'b1);
      chk("low_level_onehot", 32'(4'h1 << s), {28'h0, low_level_onehot});
      chk("high_level_onehot", 32'(2'h1 << (s % 2)), {30'h0, high_level_onehot});
      chk("selects", 32'({1'(s % 2), 2'(s)}),
        {29'h0, high_threshold_select, low_threshold_select});
    end
    wr(A_EN, 8'h04);
    sense_v <= MID_V;
    supply_v <= 8'h10;
    wait_cond(1'b1, 1'b0);
    supply_v <= MID_V;
    wait_cond(1'b0, 1'b0);
  endtask : t_levels

  task automatic t_flags;
    wr(A_EN, 8'h01);
    wr(A_FL, 8'h03);
    rd_chk("flags", A_FL, 8'h00);
    sense_v <= 8'h10;
    wait_cond(1'b1, 1'b0);
    rd_chk("flags", A_FL, 8'h01);
    irq_is(1'b0);
    wr(A_IE, 8'h01);
    irq_is(1'b1);
    cpu_run_mode <= 1'b0;
    irq_is(1'b0);
    rd_chk("flags in stop", A_FL, 8'h01);
    cpu_run_mode <= 1'b1;
    irq_is(1'b1);
    wr(A_FL, 8'h02);
    rd_chk("flags", A_FL, 8'h01);
    wr(A_FL, 8'h01);
    rd_chk("flags", A_FL, 8'h00);
    irq_is(1'b0);
    sense_v <= MID_V;
    wait_cond(1'b0, 1'b0);
    rd_chk("flags", A_FL, 8'h01);
    wr(A_FL, 8'h01);
    wr(A_IE, 8'h02);
    sense_v <= 8'hf0;
    wait_cond(1'b0, 1'b1);
    rd_chk("flags", A_FL, 8'h02);
    irq_is(1'b1);
    wr(A_FL, 8'h01);
    rd_chk("flags", A_FL, 8'h02);
    wr(A_FL, 8'h02);
    rd_chk("flags", A_FL, 8'h00);
    irq_is(1'b0);
    sense_v <= MID_V;
    wait_cond(1'b0, 1'b0);
  endtask : t_flags

  task automatic t_disable;
    wr(A_IE, 8'h01);
    sense_v <= 8'h10;
    wait_cond(1'b1, 1'b0);
    wr(A_FL, 8'h03);
    wr(A_EN, 8'h00);
    wait_cond(1'b0, 1'b0);
    rd_chk("flags after disable", A_FL, 8'h01);
    irq_is(1'b1);
    wr(A_EN, 8'h01);
    wait_cond(1'b1, 1'b0);
    wr(A_FL, 8'h03);
    wr(A_IE, 8'h00);
    wr(A_EN, 8'h00);
    wait_cond(1'b0, 1'b0);
    rd_chk("flags after disable", A_FL, 8'h01);
    irq_is(1'b0);
  endtask : t_disable

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  // Main sequence
  initial begin
    rst = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    cpu_run_mode = 1'b1;
    sense_v = MID_V;
    supply_v = MID_V;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs();
    t_levels();
    t_flags();
    t_disable();
    end_sim();
  end

  // Hang guard, far beyond the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    end_sim();
  end
endmodule : tb_svlm_top
